// file: hw/i2c_slave_port.sv
`timescale 1ns/1ps
module i2c_slave_port #(
    parameter int ADR_W = 8
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic slave_irq_o,
    output logic master_irq_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    i2c_slave_pkg::line_t sync1, sync2, sync3;
    i2c_slave_pkg::ctrl_t ctrl;
    i2c_slave_pkg::state_t state, next_state, after_ack;
    logic [3:0] bit_cnt;
    logic [7:0] rx_shift_reg, tx_shift, rx_buffer, tx_register;
    logic [9:0] slave_address;
    logic rx_full_flag, tx_full_flag, rx_overflow_flag, full_addr_match_flag;
    logic slave_event_flag, master_event_flag, addressed_state;
    logic clock_release, soft_clr_pend, tx_loaded, ack_seen, ack_from_addr;
    logic sda_oe_n, next_sda_oe_n;

    // ------------------------------------------------------------
    // pin synchronisers and line events
    // ------------------------------------------------------------
    // two flops per pin, third stage only for edge finding
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            sync1 <= i2c_slave_pkg::LINE_IDLE;
            sync2 <= i2c_slave_pkg::LINE_IDLE;
            sync3 <= i2c_slave_pkg::LINE_IDLE;
        end else begin
            sync1 <= '{scl: scl_i, sda: sda_i};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    wire scl_rise = sync2.scl & ~sync3.scl;
    wire scl_fall = ~sync2.scl & sync3.scl;
    wire scl_high = sync2.scl & sync3.scl;
    wire start_det = scl_high & sync3.sda & ~sync2.sda;
    wire stop_det = scl_high & ~sync3.sda & sync2.sda;
    wire bus_reset = ~ctrl.port_enable | start_det | stop_det;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_req & wb_we_i;
    wire bus_rd = bus_req & ~wb_we_i;
    wire hit_ctrl = wb_adr_i == ADR_W'(i2c_slave_pkg::OFS_CONTROL);
    wire hit_status = wb_adr_i == ADR_W'(i2c_slave_pkg::OFS_STATUS);
    wire hit_addr = wb_adr_i == ADR_W'(i2c_slave_pkg::OFS_SLAVE_ADDR);
    wire hit_tx = wb_adr_i == ADR_W'(i2c_slave_pkg::OFS_TX_REG);
    wire hit_rx = wb_adr_i == ADR_W'(i2c_slave_pkg::OFS_RX_BUF);
    wire wr_ctrl = bus_wr & hit_ctrl & wb_sel_i[0];
    wire wr_status = bus_wr & hit_status & wb_sel_i[0];
    wire wr_tx = bus_wr & hit_tx & wb_sel_i[0];
    wire rd_rx = bus_rd & hit_rx;
    wire sw_set = wr_ctrl & wb_dat_i[i2c_slave_pkg::CTL_RELEASE];
    wire sw_clear_req = wr_ctrl & ~wb_dat_i[i2c_slave_pkg::CTL_RELEASE]
        & ctrl.stretch_enable;
    wire w1c_ovf = wr_status & wb_dat_i[i2c_slave_pkg::STS_OVERFLOW];
    wire w1c_slave = wr_status & wb_dat_i[i2c_slave_pkg::STS_SLAVE_EV];
    wire w1c_master = wr_status & wb_dat_i[i2c_slave_pkg::STS_MASTER_EV];

    // read data selection, unmapped reads give zero
    wire [31:0] ctrl_word = {28'h0000000, clock_release, ctrl};
    wire [31:0] status_word = {24'h000000, addressed_state, state == i2c_slave_pkg::st_tx,
        master_event_flag, slave_event_flag, full_addr_match_flag,
        rx_overflow_flag, tx_full_flag, rx_full_flag};
    wire [31:0] rd_word = hit_ctrl ? ctrl_word :
        hit_status ? status_word :
        hit_addr ? {22'h000000, slave_address} :
        hit_tx ? {24'h000000, tx_register} :
        hit_rx ? {24'h000000, rx_buffer} : i2c_slave_pkg::WORD_ZERO;

    // ------------------------------------------------------------
    // address and byte decisions
    // ------------------------------------------------------------
    wire ten = ctrl.ten_bit_mode_sel;
    wire rw_bit = rx_shift_reg[0];
    wire byte8_fall = scl_fall & (bit_cnt == i2c_slave_pkg::BYTE_BITS);
    wire addr7_match = rx_shift_reg[7:1] == slave_address[6:0];
    wire hi_match = (rx_shift_reg[7:3] == i2c_slave_pkg::TEN_BIT_PREFIX)
        & (rx_shift_reg[2:1] == slave_address[9:8]);
    wire lo_match = rx_shift_reg == slave_address[7:0];
    // repeated start with read only after a full ten-bit match
    wire hi_take = hi_match & (~rw_bit | addressed_state);
    wire addr_take = ten ? hi_take : addr7_match;
    wire in_addr = state == i2c_slave_pkg::st_addr;
    wire in_addr2 = state == i2c_slave_pkg::st_addr2;
    wire in_rx = state == i2c_slave_pkg::st_rx;
    wire in_tx = state == i2c_slave_pkg::st_tx;
    wire in_ack_in = state == i2c_slave_pkg::st_ack_in;
    wire in_ack_out = state == i2c_slave_pkg::st_ack_out;
    wire shifting_in = in_addr | in_addr2 | in_rx;
    wire rx_data_done = in_rx & byte8_fall & ~bus_reset;
    wire give_ack = in_rx ? (~rx_full_flag & ~rx_overflow_flag) : 1'h1;
    wire enter_ack_in = (next_state == i2c_slave_pkg::st_ack_in) & ~in_ack_in;
    wire ack_in_end = in_ack_in & scl_fall & ~bus_reset;
    wire ack_out_end = in_ack_out & scl_fall & ~bus_reset;
    wire tx_begin = (ack_in_end & (after_ack == i2c_slave_pkg::st_tx))
        | (ack_out_end & ack_seen);
    wire tx_load = tx_full_flag & ((tx_begin) | (in_tx & ~tx_loaded & ~bus_reset));
    wire addr1_done = in_addr & byte8_fall & ~bus_reset;
    wire addr2_done = in_addr2 & byte8_fall & ~bus_reset;
    // which state follows the acknowledge of this byte
    wire [2:0] addr_next = rw_bit ? i2c_slave_pkg::st_tx :
        (ten ? i2c_slave_pkg::st_addr2 : i2c_slave_pkg::st_rx);

    // automatic stretch causes, all on a ninth falling edge
    wire tx_stretch = tx_begin & ~tx_full_flag;
    wire rx_stretch = ack_in_end & ~ack_from_addr & ctrl.stretch_enable
        & rx_full_flag;
    wire addr_stretch = ack_in_end & ack_from_addr & ten & ctrl.stretch_enable
        & (after_ack != i2c_slave_pkg::st_tx);
    wire hw_clear = tx_stretch | rx_stretch | addr_stretch;
    wire soft_clear_apply = soft_clr_pend & scl_fall;
    wire slave_event = ack_in_end | ack_out_end;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // port idles until a start condition opens an address byte
    always_comb begin
        next_state = state;
        if (!ctrl.port_enable || stop_det) begin
            next_state = i2c_slave_pkg::st_idle;
        end else if (start_det) begin
            next_state = i2c_slave_pkg::st_addr;
        end else begin
            case (state)
                i2c_slave_pkg::st_idle: begin
                    next_state = i2c_slave_pkg::st_idle;
                end
                i2c_slave_pkg::st_addr: begin
                    if (byte8_fall) begin
                        next_state = addr_take ? i2c_slave_pkg::st_ack_in : i2c_slave_pkg::st_idle;
                    end
                end
                i2c_slave_pkg::st_addr2: begin
                    if (byte8_fall) begin
                        next_state = lo_match ? i2c_slave_pkg::st_ack_in : i2c_slave_pkg::st_idle;
                    end
                end
                i2c_slave_pkg::st_rx: begin
                    if (byte8_fall) begin
                        next_state = i2c_slave_pkg::st_ack_in;
                    end
                end
                i2c_slave_pkg::st_ack_in: begin
                    if (scl_fall) begin
                        next_state = after_ack;
                    end
                end
                i2c_slave_pkg::st_tx: begin
                    if (byte8_fall) begin
                        next_state = i2c_slave_pkg::st_ack_out;
                    end
                end
                i2c_slave_pkg::st_ack_out: begin
                    if (scl_fall) begin
                        next_state = ack_seen ? i2c_slave_pkg::st_tx : i2c_slave_pkg::st_idle;
                    end
                end
                default: begin
                    next_state = i2c_slave_pkg::st_idle;
                end
            endcase
        end
    end

    // data line: acknowledge, transmit bits, release otherwise
    always_comb begin
        next_sda_oe_n = sda_oe_n;
        if (bus_reset) begin
            next_sda_oe_n = 1'h1;
        end else if (enter_ack_in) begin
            next_sda_oe_n = ~give_ack;
        end else if (tx_load) begin
            next_sda_oe_n = tx_register[7];
        end else if (ack_in_end || ack_out_end || (in_tx && byte8_fall)) begin
            next_sda_oe_n = 1'h1;
        end else if (in_tx && scl_fall && bit_cnt != i2c_slave_pkg::BIT_ZERO) begin
            next_sda_oe_n = tx_shift[6];
        end
    end

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            state <= i2c_slave_pkg::st_idle;
            after_ack <= i2c_slave_pkg::st_idle;
            ack_from_addr <= 1'h0;
        end else begin
            state <= next_state;
            if (enter_ack_in) begin
                after_ack <= in_addr ? i2c_slave_pkg::state_t'(addr_next) : i2c_slave_pkg::st_rx;
                ack_from_addr <= ~in_rx;
            end
        end
    end

    // bit counter and receive shifter, bits taken on clock rise
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            bit_cnt <= i2c_slave_pkg::BIT_ZERO;
            rx_shift_reg <= i2c_slave_pkg::BYTE_RST;
        end else if (bus_reset || byte8_fall || ack_in_end || ack_out_end) begin
            bit_cnt <= i2c_slave_pkg::BIT_ZERO;
        end else if (scl_rise && (shifting_in || in_tx)) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (shifting_in) begin
                rx_shift_reg <= {rx_shift_reg[6:0], sync2.sda};
            end
        end
    end

    // transmit shifter and master acknowledge capture
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            tx_shift <= i2c_slave_pkg::BYTE_RST;
            tx_loaded <= 1'h0;
            ack_seen <= 1'h0;
        end else begin
            if (tx_load) begin
                tx_shift <= tx_register;
                tx_loaded <= 1'h1;
            end else if (tx_stretch || bus_reset) begin
                tx_loaded <= 1'h0;
            end else if (in_tx && scl_fall) begin
                tx_shift <= {tx_shift[6:0], 1'h0};
            end
            if (in_ack_out && scl_rise) begin
                ack_seen <= ~sync2.sda;
            end
        end
    end

    // receive buffer and its flags, hardware set beats software clear
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rx_buffer <= i2c_slave_pkg::BYTE_RST;
            rx_full_flag <= 1'h0;
            rx_overflow_flag <= 1'h0;
        end else begin
            if (rx_data_done && !rx_full_flag) begin
                rx_buffer <= rx_shift_reg;
            end
            rx_full_flag <= (rx_data_done & ~rx_full_flag) | (rx_full_flag & ~rd_rx);
            rx_overflow_flag <= (rx_data_done & rx_full_flag) | (rx_overflow_flag & ~w1c_ovf);
        end
    end

    // ten-bit match tracking
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            full_addr_match_flag <= 1'h0;
            addressed_state <= 1'h0;
        end else if (!ctrl.port_enable || stop_det) begin
            addressed_state <= 1'h0;
        end else if (addr2_done) begin
            full_addr_match_flag <= lo_match;
            addressed_state <= lo_match;
        end else if (addr1_done && ten && !(hi_match && rw_bit && addressed_state)) begin
            full_addr_match_flag <= 1'h0;
            addressed_state <= 1'h0;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            ctrl <= i2c_slave_pkg::CTRL_RST;
            slave_address <= i2c_slave_pkg::SLAVE_ADDR_RST;
            tx_register <= i2c_slave_pkg::BYTE_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= wb_dat_i[2:0];
            end
            if (bus_wr && hit_addr && wb_sel_i[0]) begin
                slave_address[7:0] <= wb_dat_i[7:0];
            end
            if (bus_wr && hit_addr && wb_sel_i[1]) begin
                slave_address[9:8] <= wb_dat_i[9:8];
            end
            if (wr_tx) begin
                tx_register <= wb_dat_i[7:0];
            end
        end
    end

    // transmit full: a write sets it, a load into the shifter clears it
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            tx_full_flag <= 1'h0;
        end else begin
            tx_full_flag <= wr_tx | (tx_full_flag & ~tx_load);
        end
    end

    // release bit: set wins, clears wait for a clock fall
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            clock_release <= 1'h1;
            soft_clr_pend <= 1'h0;
        end else begin
            if (sw_set || !ctrl.port_enable) begin
                clock_release <= 1'h1;
            end else if (hw_clear || soft_clear_apply) begin
                clock_release <= 1'h0;
            end
            // with stretching off a clearing write never arms
            if (sw_set || scl_fall || !ctrl.stretch_enable) begin
                soft_clr_pend <= 1'h0;
            end else if (sw_clear_req) begin
                soft_clr_pend <= 1'h1;
            end
        end
    end

    // event flags, sticky until written with one
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            slave_event_flag <= 1'h0;
            master_event_flag <= 1'h0;
        end else begin
            slave_event_flag <= slave_event | (slave_event_flag & ~w1c_slave);
            master_event_flag <= master_event_flag & ~w1c_master;
        end
    end

    // ------------------------------------------------------------
    // outputs, all registered
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            sda_oe_n <= 1'h1;
            scl_oe_n_o <= 1'h1;
            slave_irq_o <= 1'h0;
            master_irq_o <= 1'h0;
            wb_ack_o <= 1'h0;
            wb_dat_o <= i2c_slave_pkg::WORD_ZERO;
        end else begin
            sda_oe_n <= next_sda_oe_n;
            scl_oe_n_o <= clock_release | ~ctrl.port_enable;
            slave_irq_o <= slave_event;
            master_irq_o <= 1'h0;
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_rd ? rd_word : i2c_slave_pkg::WORD_ZERO;
        end
    end

    // lines are only ever pulled low
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            scl_o <= 1'h0;
            sda_o <= 1'h0;
        end else begin
            scl_o <= 1'h0;
            sda_o <= 1'h0;
        end
    end
    assign sda_oe_n_o = sda_oe_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    a_addr7_ack: assert property (in_addr && byte8_fall && !ten && addr7_match && !bus_reset
        |=> in_ack_in && !sda_oe_n) else $error("seven-bit match not acknowledged");
    a_addr7_miss: assert property (in_addr && byte8_fall && !ten && !addr7_match && !bus_reset
        |=> state == i2c_slave_pkg::st_idle && sda_oe_n) else $error("mismatch not idle");
    a_full_nack: assert property (rx_data_done && rx_full_flag
        |=> sda_oe_n && $stable(rx_buffer) && rx_overflow_flag) else $error("full byte taken");
    a_ovf_load: assert property (rx_data_done && !rx_full_flag && rx_overflow_flag
        |=> sda_oe_n && rx_buffer == $past(rx_shift_reg)) else $error("overflow load wrong");
    a_event_pulse: assert property (slave_event
        |=> slave_irq_o && slave_event_flag) else $error("slave event missing");
    a_tx_stretch: assert property (tx_stretch && !sw_set
        |=> !clock_release ##1 !scl_oe_n_o) else $error("transmit stretch missing");
    a_tx_early: assert property (tx_begin && tx_full_flag
        |=> tx_loaded && !tx_full_flag) else $error("early load not used");
    a_clear_on_fall: assert property ($fell(clock_release)
        |-> $past(scl_fall)) else $error("release cleared off a clock fall");
    a_set_anytime: assert property (sw_set
        |=> clock_release) else $error("release set ignored");
    a_ten_hi: assert property (addr1_done && ten && hi_match && !rw_bit
        |=> in_ack_in && after_ack == i2c_slave_pkg::st_addr2 && !full_addr_match_flag)
        else $error("ten-bit first byte wrong");

    c_rx_byte: cover property (rx_data_done && !rx_full_flag);
    c_tx_byte: cover property (ack_out_end && ack_seen);
    c_overflow: cover property (rx_data_done && rx_full_flag);
    c_ten_match: cover property (addr2_done && lo_match);

endmodule

// file: hw/i2c_slave_pkg.sv
// Operation
// - ten-bit address register, seven-bit when mode clear
// - seven-bit: address bits 6:0 versus shift 7:1
// - idle until start, then shift eight bits
// - sample every data bit on clock rise
// - match: acknowledge, flag event, buffer untouched
// - read direction: acknowledge, stretch if empty until release bit set, shift
// - transmit event pulse regardless of master acknowledge
// - write direction: receive, buffer if empty, acknowledge
// - buffer full: no acknowledge, pulse, keep buffer
// - overflow without full: load buffer, not acknowledge
// - ten-bit first byte against prefix and bits 9:8
// - ten-bit second byte against bits 7:0
// - transmit: empty register at ninth fall stretches clock
// - transmit register loaded early: no stretch
// - receive stretch when buffer full at ninth fall
// - buffer read early: no receive stretch
// - software may set release bit any time
// - ten-bit stretching during address, then per byte
// - software clear acts only after clock fall
// - stretch disabled: software clear of release ignored
// - master and slave event flags; the master flag is never set, only cleared
// - receive path double buffered with event pulse
package i2c_slave_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SLAVE_ADDR = 8'h08;
    localparam logic [7:0] OFS_TX_REG = 8'h0C;
    localparam logic [7:0] OFS_RX_BUF = 8'h10;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL_ENABLE = 0;
    localparam int CTL_TEN_BIT = 1;
    localparam int CTL_STRETCH = 2;
    localparam int CTL_RELEASE = 3;
    localparam int STS_RX_FULL = 0;
    localparam int STS_TX_FULL = 1;
    localparam int STS_OVERFLOW = 2;
    localparam int STS_FULL_MATCH = 3;
    localparam int STS_SLAVE_EV = 4;
    localparam int STS_MASTER_EV = 5;
    localparam int STS_TX_MODE = 6;
    localparam int STS_ADDRESSED = 7;

    // ------------------------------------------------------------
    // widths, codes and reset values
    // ------------------------------------------------------------
    localparam int ADDR_BITS = 10;
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [9:0] SLAVE_ADDR_RST = 10'h000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic stretch_enable;
        logic ten_bit_mode_sel;
        logic port_enable;
    } ctrl_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } line_t;

    localparam ctrl_t CTRL_RST = 3'h0;
    localparam line_t LINE_IDLE = 2'h3;

    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_addr2,
        st_rx,
        st_ack_in,
        st_tx,
        st_ack_out
    } state_t;

endpackage

// file: sim/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
    input wire logic scl_w,
    input wire logic sda_w,
    output logic scl_m,
    output logic sda_m
);
    // ------------------------------------------------------------
    // open-drain bus master, 200 ns clock period
    // ------------------------------------------------------------
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    // data changes only while the clock is low, then is read back before the fall
    task automatic bit_io(input logic b, output logic s);
        sda_m = b;
        #130;
        scl_m = 1'b1;
        wait (scl_w === 1'b1); // slave may be stretching
        #50;
        s = sda_w;
        scl_m = 1'b0;
        #20;
    endtask
    // msb first, then the ninth bit
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(a, k);
    endtask
    task automatic start();
        sda_m = 1'b1;
        scl_m = 1'b1;
        #100;
        sda_m = 1'b0;
        #100;
        scl_m = 1'b0;
        #20;
    endtask
    task automatic stop();
        sda_m = 1'b0;
        #130;
        scl_m = 1'b1;
        #100;
        sda_m = 1'b1;
        #100;
    endtask
endmodule

// file: sim/i2c_slave_addr_and_clock_stretch_tb_top.sv
`timescale 1ns/1ps
module i2c_slave_addr_and_clock_stretch_tb_top;
    // ------------------------------------------------------------
    // stimulus, pins and bookkeeping
    // ------------------------------------------------------------
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o, q;
    logic wb_ack_o, scl_oe_n_o, sda_oe_n_o, scl_m, sda_m, k;
    logic [7:0] r;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    wire scl_w = scl_m & scl_oe_n_o; // wired and with pull-up
    wire sda_w = sda_m & sda_oe_n_o;
    i2c_slave_port dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(4'hF), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_w),
        .sda_i(sda_w), .scl_o(), .scl_oe_n_o(scl_oe_n_o), .sda_o(), .sda_oe_n_o(sda_oe_n_o),
        .slave_irq_o(), .master_irq_o());
    i2c_master_model m_u (.scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    // hang guard
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end
    // classic wishbone cycle, held until ack is sampled
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        // let the last line event clear the synchronisers first
        repeat (8) @(posedge mclk_i);
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic report_and_stop();
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge mclk_i);
        nrst_i <= 1'b1;
        wb(i2c_slave_pkg::OFS_CONTROL, 1'b0, 32'h0);
        check("control", q, 32'h0000_0008);
        wb(i2c_slave_pkg::OFS_SLAVE_ADDR, 1'b0, 32'h0);
        check("slave_address", q, 32'h0000_0000);
        wb(i2c_slave_pkg::OFS_SLAVE_ADDR, 1'b1, 32'h0000_002A);
        wb(8'h40, 1'b0, 32'h0);
        check("unmapped", q, 32'h0000_0000);
        wb(i2c_slave_pkg::OFS_CONTROL, 1'b1, 32'h0000_0001);
        wb(i2c_slave_pkg::OFS_CONTROL, 1'b0, 32'h0);
        check("release kept", q, 32'h0000_0009);
        m_u.start();
        m_u.xfer(8'h56, 1'b1, r, k);
        check("other address", {31'h0, k}, 32'h1);
        m_u.stop();
        m_u.start();
        m_u.xfer(8'h54, 1'b1, r, k);
        check("address ack", {31'h0, k}, 32'h0);
        wb(i2c_slave_pkg::OFS_STATUS, 1'b0, 32'h0);
        check("status event", q & 32'h13, 32'h10);
        m_u.xfer(8'hA5, 1'b1, r, k);
        check("data ack", {31'h0, k}, 32'h0);
        m_u.xfer(8'h3C, 1'b1, r, k);
        check("full nack", {31'h0, k}, 32'h1);
        m_u.stop();
        wb(i2c_slave_pkg::OFS_STATUS, 1'b0, 32'h0);
        check("status full", q & 32'h07, 32'h05);
        wb(i2c_slave_pkg::OFS_RX_BUF, 1'b0, 32'h0);
        check("rx_buffer", q, 32'h0000_00A5);
        m_u.start();
        m_u.xfer(8'h54, 1'b1, r, k);
        m_u.xfer(8'h81, 1'b1, r, k);
        check("overflow nack", {31'h0, k}, 32'h1);
        m_u.stop();
        wb(i2c_slave_pkg::OFS_RX_BUF, 1'b0, 32'h0);
        check("rx_buffer", q, 32'h0000_0081);
        wb(i2c_slave_pkg::OFS_TX_REG, 1'b1, 32'h0000_00C3);
        m_u.start();
        m_u.xfer(8'h55, 1'b1, r, k);
        check("read ack", {31'h0, k}, 32'h0);
        m_u.xfer(8'hFF, 1'b1, r, k);
        check("tx byte", {24'h0, r}, 32'h0000_00C3);
        m_u.stop();
        wb(i2c_slave_pkg::OFS_CONTROL, 1'b0, 32'h0);
        check("release set", q, 32'h0000_0009);
        wb(i2c_slave_pkg::OFS_CONTROL, 1'b1, 32'h0000_0003);
        m_u.start();
        m_u.xfer(8'hF0, 1'b1, r, k);
        check("ten-bit high ack", {31'h0, k}, 32'h0);
        m_u.xfer(8'h2A, 1'b1, r, k);
        check("ten-bit low ack", {31'h0, k}, 32'h0);
        m_u.stop();
        wb(i2c_slave_pkg::OFS_STATUS, 1'b0, 32'h0);
        check("full match", q & 32'h08, 32'h08);
        report_and_stop();
    end
endmodule
